// ---- hw/gpr_pkg.sv ----
package gpr_pkg;
    localparam int DATA_W = 32;
    localparam int IDX_W = 4;
    localparam int NUM_GPR = 16;
    localparam int AUX_IDX_W = 2;
    localparam int NUM_AUX = 4;
    localparam logic [IDX_W-1:0] INDEX_REG = 4'h0;
    localparam logic [IDX_W-1:0] STACK_REG = 4'hf;
    localparam logic [DATA_W-1:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [DATA_W-1:0] AUX_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // exception stack sequencer
    typedef enum logic [4:0] {
        EXC_IDLE = 5'b00001,
        EXC_PUSH_SR = 5'b00010,
        EXC_PUSH_PC = 5'b00100,
        EXC_POP_PC = 5'b01000,
        EXC_POP_SR = 5'b10000
    } exc_state_e;
endpackage

// ---- hw/aux_reg_bank.sv ----
`timescale 1ns/100ps
// four-entry bank used for both the control and the system registers
module aux_reg_bank (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // write side
    input wire logic wr_en,
    input wire logic [gpr_pkg::AUX_IDX_W-1:0] wr_idx,
    input wire logic [gpr_pkg::DATA_W-1:0] wr_data,
    // read side, registered
    input wire logic [gpr_pkg::AUX_IDX_W-1:0] rd_idx,
    output logic [gpr_pkg::DATA_W-1:0] rd_data
);
    import gpr_pkg::*;

    logic [DATA_W-1:0] bank_r [NUM_AUX];

    // each entry is its own flop group with a defined reset value
    genvar g;
    generate
        for (g = 0; g < NUM_AUX; g++) begin : g_ent
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    bank_r[g] <= AUX_RESET;
                end else if (wr_en && wr_idx == AUX_IDX_W'(g)) begin
                    bank_r[g] <= wr_data;
                end
            end
        end
    endgenerate

    // registered read keeps the output straight off a flop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_data <= AUX_RESET;
        end else begin
            rd_data <= bank_r[rd_idx];
        end
    end

    a_aux_write_read: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_en && rd_idx == wr_idx ##1 rd_idx == $past(wr_idx)
        |=> rd_data == $past(wr_data, 2))
        else $error("aux bank read did not return the written word");
endmodule

// ---- hw/general_register_file.sv ----
`timescale 1ns/100ps
module general_register_file (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // read port a (operand)
    input wire logic [gpr_pkg::IDX_W-1:0] rd_a_idx,
    input wire logic rd_a_force_zero,
    output logic [gpr_pkg::DATA_W-1:0] rd_a_data,
    // read port b (operand)
    input wire logic [gpr_pkg::IDX_W-1:0] rd_b_idx,
    output logic [gpr_pkg::DATA_W-1:0] rd_b_data,
    // datapath write port
    input wire logic wr_en,
    input wire logic [gpr_pkg::IDX_W-1:0] wr_idx,
    input wire logic wr_force_zero,
    input wire logic [gpr_pkg::DATA_W-1:0] wr_data,
    // address generation
    input wire logic [gpr_pkg::IDX_W-1:0] agen_base_idx,
    input wire logic agen_indexed,
    input wire logic [gpr_pkg::DATA_W-1:0] agen_disp,
    output logic [gpr_pkg::DATA_W-1:0] agen_addr,
    // exception sequencer
    input wire logic exc_enter,
    input wire logic exc_return,
    input wire logic [gpr_pkg::DATA_W-1:0] status_word,
    input wire logic [gpr_pkg::DATA_W-1:0] program_counter,
    output logic exc_busy,
    output logic exc_done,
    output logic [gpr_pkg::DATA_W-1:0] restored_status_word,
    output logic [gpr_pkg::DATA_W-1:0] restored_program_counter,
    // stack memory port
    output logic mem_req,
    output logic mem_we,
    output logic [gpr_pkg::DATA_W-1:0] mem_addr,
    output logic [gpr_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [gpr_pkg::DATA_W-1:0] mem_rdata,
    input wire logic mem_ack,
    // control and system registers
    input wire logic aux_wr_en,
    input wire logic aux_sel_system,
    input wire logic [gpr_pkg::AUX_IDX_W-1:0] aux_wr_idx,
    input wire logic [gpr_pkg::DATA_W-1:0] aux_wr_data,
    input wire logic [gpr_pkg::AUX_IDX_W-1:0] aux_rd_idx,
    output logic [gpr_pkg::DATA_W-1:0] ctrl_rd_data,
    output logic [gpr_pkg::DATA_W-1:0] sys_rd_data
);
    import gpr_pkg::*;

    // general file; contents are undefined until software loads them
    logic [DATA_W-1:0] gpr_r [NUM_GPR];
    exc_state_e state_r, state_nxt;
    logic [DATA_W-1:0] pc_hold_r;

    // index selection with the zero override
    function automatic logic [IDX_W-1:0] pick_idx(
        input logic [IDX_W-1:0] idx,
        input logic force_zero
    );
        pick_idx = force_zero ? INDEX_REG : idx;
    endfunction

    wire [IDX_W-1:0] rd_a_eff = pick_idx(rd_a_idx, rd_a_force_zero);
    wire [IDX_W-1:0] wr_eff = pick_idx(wr_idx, wr_force_zero);
    wire [DATA_W-1:0] sp_val = gpr_r[STACK_REG];
    wire [DATA_W-1:0] base_val = gpr_r[agen_base_idx];
    wire [DATA_W-1:0] index_val = gpr_r[INDEX_REG];

    // read ports are combinational so the decoder sees data the same cycle;
    // this is the one place where top outputs skip a flop
    assign rd_a_data = gpr_r[rd_a_eff];
    assign rd_b_data = gpr_r[rd_b_idx];

    // stack pointer update, taken when a stack beat is acknowledged
    wire in_push = (state_r == EXC_PUSH_SR) || (state_r == EXC_PUSH_PC);
    wire in_pop = (state_r == EXC_POP_PC) || (state_r == EXC_POP_SR);
    wire sp_wr_en = mem_ack && (in_push || in_pop);
    wire [DATA_W-1:0] sp_wr_data = in_push ? mem_addr
                                           : mem_addr + WORD_BYTES;
    wire dp_blocked = sp_wr_en && (wr_eff == STACK_REG);
    wire dp_wr_go = wr_en && !dp_blocked;

    // write port: the sequencer wins a same-cycle clash on the pointer
    always_ff @(posedge clock) begin
        if (dp_wr_go) begin
            gpr_r[wr_eff] <= wr_data;
        end
        if (sp_wr_en) begin
            gpr_r[STACK_REG] <= sp_wr_data;
        end
    end

    // effective address: base plus index register zero or a displacement
    wire [DATA_W-1:0] agen_nxt = agen_indexed ? base_val + index_val
                                              : base_val + agen_disp;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            agen_addr <= WORD_ZERO;
        end else begin
            agen_addr <= agen_nxt;
        end
    end

    // sequencer next state; entry wins if both requests come together
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            EXC_IDLE: begin
                if (exc_enter) begin
                    state_nxt = EXC_PUSH_SR;
                end else if (exc_return) begin
                    state_nxt = EXC_POP_PC;
                end
            end
            EXC_PUSH_SR: begin
                if (mem_ack) begin
                    state_nxt = EXC_PUSH_PC;
                end
            end
            EXC_POP_PC: begin
                if (mem_ack) begin
                    state_nxt = EXC_POP_SR;
                end
            end
            EXC_PUSH_PC, EXC_POP_SR: begin
                if (mem_ack) begin
                    state_nxt = EXC_IDLE;
                end
            end
            default: state_nxt = EXC_IDLE;
        endcase
    end

    wire last_beat = mem_ack && (state_r == EXC_PUSH_PC
                                 || state_r == EXC_POP_SR);
    wire start_push = (state_r == EXC_IDLE) && exc_enter;
    wire start_pop = (state_r == EXC_IDLE) && !exc_enter && exc_return;

    // status and busy flags
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= EXC_IDLE;
            exc_busy <= 1'b0;
            exc_done <= 1'b0;
        end else begin
            state_r <= state_nxt;
            exc_busy <= (state_nxt != EXC_IDLE);
            exc_done <= last_beat;
        end
    end

    // stack memory beats: status word pushed first, so it pops last
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= WORD_ZERO;
            mem_wdata <= WORD_ZERO;
            pc_hold_r <= WORD_ZERO;
        end else if (start_push) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= sp_val - WORD_BYTES;
            mem_wdata <= status_word;
            pc_hold_r <= program_counter;
        end else if (start_pop) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= sp_val;
        end else if (mem_ack && state_r == EXC_PUSH_SR) begin
            mem_addr <= mem_addr - WORD_BYTES;
            mem_wdata <= pc_hold_r;
        end else if (mem_ack && state_r == EXC_POP_PC) begin
            mem_addr <= mem_addr + WORD_BYTES;
        end else if (last_beat) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
        end
    end

    // restored words are held until the next return overwrites them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            restored_program_counter <= WORD_ZERO;
            restored_status_word <= WORD_ZERO;
        end else if (mem_ack && state_r == EXC_POP_PC) begin
            restored_program_counter <= mem_rdata;
        end else if (mem_ack && state_r == EXC_POP_SR) begin
            restored_status_word <= mem_rdata;
        end
    end

    // control and system registers live outside the general file
    aux_reg_bank u_ctrl_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_en(aux_wr_en && !aux_sel_system),
        .wr_idx(aux_wr_idx),
        .wr_data(aux_wr_data),
        .rd_idx(aux_rd_idx),
        .rd_data(ctrl_rd_data)
    );
    aux_reg_bank u_sys_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_en(aux_wr_en && aux_sel_system),
        .wr_idx(aux_wr_idx),
        .wr_data(aux_wr_data),
        .rd_idx(aux_rd_idx),
        .rd_data(sys_rd_data)
    );

    a_datapath_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_en && !(sp_wr_en && wr_eff == STACK_REG)
        |=> gpr_r[$past(wr_eff)] == $past(wr_data))
        else $error("datapath write not stored");

    a_zero_forced_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_en && wr_force_zero |=> gpr_r[0] == $past(wr_data))
        else $error("forced write missed register zero");

    a_stack_priority: assert property (
        @(posedge clock) disable iff (sys_rst)
        sp_wr_en && wr_en |=> gpr_r[STACK_REG] == $past(sp_wr_data))
        else $error("stack pointer lost to datapath write");

    a_entry_first_push: assert property (
        @(posedge clock) disable iff (sys_rst)
        start_push |=> mem_req && mem_we && mem_wdata == $past(status_word)
        && mem_addr == $past(sp_val) - WORD_BYTES)
        else $error("entry did not push status word below pointer");

    a_entry_second_push: assert property (
        @(posedge clock) disable iff (sys_rst)
        state_r == EXC_PUSH_SR && mem_ack |=> mem_req && mem_we
        && mem_wdata == pc_hold_r && mem_addr == $past(mem_addr) - WORD_BYTES)
        else $error("program counter push misplaced");

    a_entry_pointer_end: assert property (
        @(posedge clock) disable iff (sys_rst)
        state_r == EXC_PUSH_PC && mem_ack
        |=> exc_done && !mem_req && gpr_r[STACK_REG] == $past(mem_addr))
        else $error("pointer wrong after exception entry");

    a_return_first_pop: assert property (
        @(posedge clock) disable iff (sys_rst)
        start_pop |=> mem_req && !mem_we && mem_addr == $past(sp_val))
        else $error("return did not read at the pointer");

    a_return_restore: assert property (
        @(posedge clock) disable iff (sys_rst)
        state_r == EXC_POP_SR && mem_ack |=> exc_done
        && restored_status_word == $past(mem_rdata)
        && gpr_r[STACK_REG] == $past(mem_addr) + WORD_BYTES)
        else $error("status word or pointer wrong after return");

    a_indexed_address: assert property (
        @(posedge clock) disable iff (sys_rst)
        agen_indexed |=> agen_addr == $past(base_val) + $past(index_val))
        else $error("indexed address is not base plus register zero");
endmodule

// ---- tb/stack_mem_model.sv ----
`timescale 1ns/100ps
// stack memory behind the core; each beat waits delay cycles for its ack
module stack_mem_model (
    // clock
    input wire logic clock,
    // request from the core
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [gpr_pkg::DATA_W-1:0] mem_addr,
    input wire logic [gpr_pkg::DATA_W-1:0] mem_wdata,
    // answer
    output logic [gpr_pkg::DATA_W-1:0] mem_rdata,
    output logic mem_ack,
    // wait cycles before each ack
    input wire logic [31:0] delay
);
    logic [31:0] mem [logic [31:0]];
    int cnt = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
    end
    // answer on the falling edge; outside an ack the data line flips
    // every cycle so stale read data can never pass for valid
    always @(negedge clock) begin
        if (mem_req && cnt >= delay) begin
            mem_ack = 1'b1;
            cnt = 0;
            if (mem_we) mem[mem_addr] = mem_wdata;
            else if (mem.exists(mem_addr)) mem_rdata = mem[mem_addr];
            else mem_rdata = ~mem_rdata;
        end else begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            if (mem_req) cnt++;
        end
    end
endmodule

// ---- tb/test_general_register_file.sv ----
`timescale 1ns/100ps
module test_general_register_file;
    import gpr_pkg::*;
    logic clock, sys_rst, rd_a_force_zero, wr_en, wr_force_zero, agen_indexed;
    logic [IDX_W-1:0] rd_a_idx, rd_b_idx, wr_idx, agen_base_idx;
    logic [DATA_W-1:0] rd_a_data, rd_b_data, wr_data, agen_disp, agen_addr;
    logic exc_enter, exc_return, exc_busy, exc_done, mem_req, mem_we, mem_ack;
    logic [DATA_W-1:0] status_word, program_counter, restored_status_word;
    logic [DATA_W-1:0] restored_program_counter, mem_addr, mem_wdata;
    logic [DATA_W-1:0] mem_rdata, aux_wr_data, ctrl_rd_data, sys_rd_data;
    logic aux_wr_en, aux_sel_system;
    logic [AUX_IDX_W-1:0] aux_wr_idx, aux_rd_idx;
    logic [DATA_W-1:0] gpr_m [NUM_GPR];
    logic [DATA_W-1:0] aux_m [2][NUM_AUX];
    logic [DATA_W-1:0] sp, sr, pc, exp_v;
    int delay, num_errors, checks_done;

    general_register_file i_dut (
        .clock(clock), .sys_rst(sys_rst), .rd_a_idx(rd_a_idx),
        .rd_a_force_zero(rd_a_force_zero), .rd_a_data(rd_a_data),
        .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data), .wr_en(wr_en),
        .wr_idx(wr_idx), .wr_force_zero(wr_force_zero), .wr_data(wr_data),
        .agen_base_idx(agen_base_idx), .agen_indexed(agen_indexed),
        .agen_disp(agen_disp), .agen_addr(agen_addr),
        .exc_enter(exc_enter), .exc_return(exc_return),
        .status_word(status_word), .program_counter(program_counter),
        .exc_busy(exc_busy), .exc_done(exc_done),
        .restored_status_word(restored_status_word),
        .restored_program_counter(restored_program_counter),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .aux_wr_en(aux_wr_en), .aux_sel_system(aux_sel_system),
        .aux_wr_idx(aux_wr_idx), .aux_wr_data(aux_wr_data),
        .aux_rd_idx(aux_rd_idx), .ctrl_rd_data(ctrl_rd_data),
        .sys_rd_data(sys_rd_data));

    stack_mem_model i_mem (
        .clock(clock), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .delay(delay));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input logic [DATA_W-1:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // write stays raised so writes can run back to back; caller lowers it
    task automatic wr(input logic [IDX_W-1:0] i, input logic fz);
        wr_en = 1'b1;
        wr_idx = i;
        wr_force_zero = fz;
        wr_data = $urandom;
        gpr_m[fz ? INDEX_REG : i] = wr_data;
        @(negedge clock);
    endtask

    task automatic rd(input logic [IDX_W-1:0] a, b, input logic fz);
        rd_a_idx = a;
        rd_b_idx = b;
        rd_a_force_zero = fz;
        #1;
        chk(rd_a_data, gpr_m[fz ? INDEX_REG : a]);
        chk(rd_b_data, gpr_m[b]);
        @(negedge clock);
    endtask

    // one stack sequence; a stray request and a write land while busy
    task automatic exc(input logic ent);
        int n;
        if (ent) begin
            sr = $urandom;
            pc = $urandom;
        end
        sp = gpr_m[STACK_REG];
        status_word = sr;
        program_counter = pc;
        exc_enter = ent;
        exc_return = !ent;
        @(negedge clock);
        chk(exc_busy, 1'b1);
        exc_enter = 1'b1;
        exc_return = 1'b1;
        wr_en = 1'b1;
        wr_idx = delay == 0 ? STACK_REG : 4'h5;
        wr_data = $urandom;
        if (delay != 0) gpr_m[5] = wr_data;
        @(negedge clock);
        exc_enter = 1'b0;
        exc_return = 1'b0;
        wr_en = 1'b0;
        for (n = 0; n < 50 && exc_done !== 1'b1; n++) @(negedge clock);
        if (n == 50) begin
            num_errors++;
            stop_test();
        end
        chk({exc_busy, exc_done, mem_req}, 32'h0000_0002);
        gpr_m[STACK_REG] = ent ? sp - 8 : sp + 8;
        rd(STACK_REG, 4'h5, 1'b0);
        chk(exc_done, 1'b0);
        if (ent) begin
            chk(i_mem.mem[sp - 4], sr);
            chk(i_mem.mem[sp - 8], pc);
        end else begin
            chk(restored_status_word, sr);
            chk(restored_program_counter, pc);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        stop_test();
    end

    // main sequence
    initial begin
        void'($urandom(32'h2f45229f));
        {num_errors, checks_done, delay} = '0;
        {rd_a_force_zero, wr_en, wr_force_zero, agen_indexed} = '0;
        {rd_a_idx, rd_b_idx, wr_idx, agen_base_idx} = '0;
        {wr_data, agen_disp, status_word, program_counter} = '0;
        {exc_enter, exc_return, aux_wr_en, aux_sel_system} = '0;
        {aux_wr_idx, aux_rd_idx, aux_wr_data} = '0;
        sys_rst = 1'b1;
        repeat (10) @(negedge clock);
        chk({exc_busy, exc_done, mem_req, mem_we}, '0);
        chk(mem_addr | mem_wdata, WORD_ZERO);
        chk(restored_status_word, WORD_ZERO);
        chk(restored_program_counter, WORD_ZERO);
        chk(agen_addr | ctrl_rd_data | sys_rd_data, WORD_ZERO);
        sys_rst = 1'b0;
        @(negedge clock);
        for (int k = 0; k < NUM_GPR; k++) wr(k[3:0], 1'b0);
        wr(4'h9, 1'b1);
        wr_en = 1'b0;
        for (int k = 0; k < NUM_GPR; k++) begin
            rd(k[3:0], 4'hf - k[3:0], k[0]);
        end
        // pipelined address generation, indexed and displaced in turn
        for (int k = 0; k < NUM_GPR; k++) begin
            agen_base_idx = k[3:0];
            agen_indexed = k[0];
            agen_disp = $urandom;
            exp_v = gpr_m[k] + (k[0] ? gpr_m[INDEX_REG] : agen_disp);
            @(negedge clock);
            chk(agen_addr, exp_v);
        end
        // fill both auxiliary banks back to back, then read them all
        aux_wr_en = 1'b1;
        for (int k = 0; k < 2 * NUM_AUX; k++) begin
            aux_sel_system = k[2];
            aux_wr_idx = k[1:0];
            aux_wr_data = $urandom;
            aux_m[k[2]][k[1:0]] = aux_wr_data;
            @(negedge clock);
        end
        aux_wr_en = 1'b0;
        for (int k = 0; k < NUM_AUX; k++) begin
            aux_rd_idx = k[1:0];
            @(negedge clock);
            chk(ctrl_rd_data, aux_m[0][k]);
            chk(sys_rd_data, aux_m[1][k]);
        end
        // write stays raised from the task, so the pointer load follows it
        wr(STACK_REG, 1'b0);
        gpr_m[STACK_REG] = {gpr_m[STACK_REG][31:20], 20'h8_0000};
        wr_data = gpr_m[STACK_REG];
        @(negedge clock);
        wr_en = 1'b0;
        // prompt and slow memory, entry then return each
        for (int d = 0; d < 2; d++) begin
            delay = 3 * d;
            exc(1'b1);
            exc(1'b0);
        end
        stop_test();
    end
endmodule
